//--- verilog/rrx_pkg.sv
// package for the rotate / reverse-subtract execute block
// assumes a 32-bit register file and a flag word n,z,c,v
package rrx_pkg;
  localparam int          XLEN        = 32;
  localparam logic [3:0]  REG_SP      = 4'hd;   // stack pointer index
  localparam logic [3:0]  REG_PC      = 4'hf;   // program counter index
  localparam logic [1:0]  SHIFT_ROR   = 2'h3;   // rotate type code
  localparam logic [31:0] RESULT_RST  = 32'h0;
  localparam logic [3:0]  FLAGS_RST   = 4'h0;   // n z c v after reset
  localparam int          FLAG_N      = 3;
  localparam int          FLAG_Z      = 2;
  localparam int          FLAG_C      = 1;
  localparam int          FLAG_V      = 0;
  localparam logic [15:0] W_MOV_HI    = 16'hea4f; // wide move, flags off
  localparam logic [15:0] W_MOV_MASK  = 16'hffef; // ignore s bit
  localparam logic [15:0] W_RSBI_HI   = 16'hf1c0; // wide reverse-subtract imm
  localparam logic [15:0] W_RSBI_MASK = 16'hfbe0; // ignore i, s, source
  localparam logic [15:0] W_RORR_HI   = 16'hfa60; // wide register rotate
  localparam logic [15:0] W_RORR_MASK = 16'hffe0;
  localparam logic [9:0]  N_RORR      = 10'h107;  // short register rotate
  localparam logic [9:0]  N_RSB       = 10'h109;  // short negate
  typedef enum logic [2:0] {
    RRX_OP_NONE = 3'b000,
    RRX_OP_RORI = 3'b001,
    RRX_OP_RORR = 3'b010,
    RRX_OP_RRX  = 3'b011,
    RRX_OP_RSB  = 3'b100,
    RRX_OP_UND  = 3'b101
  } rrx_op_t;
endpackage : rrx_pkg

//--- verilog/rrx_rot.sv
// combinational rotate-right unit with carry out
// assumes the caller already picked the amount source
module rrx_rot (
  input  wire logic [31:0] i_val,
  input  wire logic [7:0]  i_amt,
  input  wire logic        i_cin,
  output logic      [31:0] o_res,
  output logic             o_cout
);
  logic [4:0] sh;
  // only the low five bits set the result; carry is kept only when the whole amount byte is zero
  always_comb begin
    sh     = i_amt[4:0];
    o_res  = (i_val >> sh) | (i_val << (6'd32 - {1'b0, sh}));
    o_cout = (i_amt == 8'h00) ? i_cin : o_res[31];
  end
endmodule : rrx_rot

//--- verilog/rrx_exec.sv
// execute stage for rotate, extended rotate and reverse subtract
// assumes fetch presents one instruction per valid cycle with operands read
module rrx_exec #(
  parameter bit MAIN_EXT = 1'b1
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic        i_is_wide,
  input  wire logic        i_in_block,
  input  wire logic        i_cond_pass,
  input  wire logic [31:0] i_src_val,
  input  wire logic [31:0] i_amt_val,
  input  wire logic [3:0]  i_flags,
  output logic             o_wr_en,
  output logic      [3:0]  o_wr_idx,
  output logic      [31:0] o_wr_data,
  output logic             o_flags_wr,
  output logic      [3:0]  o_flags,
  output logic             o_undef,
  output logic             o_unpred,
  output logic      [3:0]  o_src_idx,
  output logic      [3:0]  o_amt_idx
);
  // expand the 12-bit modified constant
  function automatic logic [31:0] modified_const_expand(input logic [11:0] c);
    logic [31:0] base;
    logic [4:0]  rot;
    base = 32'h0;
    rot  = c[11:7];
    case (c[9:8])
      2'h0:    base = {24'h0, c[7:0]};
      2'h1:    base = {8'h0, c[7:0], 8'h0, c[7:0]};
      2'h2:    base = {c[7:0], 8'h0, c[7:0], 8'h0};
      default: base = {c[7:0], c[7:0], c[7:0], c[7:0]};
    endcase
    if (c[11:10] != 2'h0) begin
      base = {24'h0, 1'b1, c[6:0]};
      base = (base >> rot) | (base << (6'd32 - {1'b0, rot}));
    end
    return base;
  endfunction : modified_const_expand

  logic [15:0] hw;
  logic [15:0] lw;
  logic [4:0]  imm_amt;
  rrx_pkg::rrx_op_t op;
  logic        setflags;
  logic [3:0]  dst_idx;
  logic [3:0]  src_idx;
  logic [3:0]  amt_idx;
  logic [31:0] rsb_imm;
  logic [31:0] rot_val;
  logic        rot_c;
  logic [7:0]  rot_amt;
  logic [32:0] sum;
  logic [31:0] res;
  logic        c_out;
  logic        v_out;
  logic        unpred;

  assign hw = i_instr[31:16];
  assign lw = i_instr[15:0];

  // decode: field extraction and operation choice
  always_comb begin
    op       = rrx_pkg::RRX_OP_NONE;
    setflags = 1'b0;
    dst_idx  = 4'h0;
    src_idx  = 4'h0;
    amt_idx  = 4'h0;
    rsb_imm  = 32'h0;
    unpred   = 1'b0;
    imm_amt  = {hw[14:12] & 3'h0, 2'h0} | {lw[14:12], lw[7:6]};
    if (!i_is_wide) begin
      if (lw[15:6] == rrx_pkg::N_RORR) begin
        op       = rrx_pkg::RRX_OP_RORR;
        setflags = !i_in_block;
        dst_idx  = {1'b0, lw[2:0]};
        src_idx  = {1'b0, lw[2:0]};
        amt_idx  = {1'b0, lw[5:3]};
      end else if (lw[15:6] == rrx_pkg::N_RSB) begin
        op       = rrx_pkg::RRX_OP_RSB;
        setflags = !i_in_block;
        dst_idx  = {1'b0, lw[2:0]};
        src_idx  = {1'b0, lw[5:3]};
        rsb_imm  = 32'h0;
      end
    end else if ((hw & rrx_pkg::W_MOV_MASK) == rrx_pkg::W_MOV_HI
                 && lw[5:4] == rrx_pkg::SHIFT_ROR) begin
      setflags = hw[4];
      dst_idx  = lw[11:8];
      src_idx  = lw[3:0];
      op = (imm_amt != 5'h00) ? rrx_pkg::RRX_OP_RORI : rrx_pkg::RRX_OP_RRX;
      if (!MAIN_EXT) op = rrx_pkg::RRX_OP_UND;
    end else if ((hw & rrx_pkg::W_RORR_MASK) == rrx_pkg::W_RORR_HI
                 && lw[15:12] == 4'hf && lw[7:4] == 4'h0) begin
      op       = MAIN_EXT ? rrx_pkg::RRX_OP_RORR : rrx_pkg::RRX_OP_UND;
      setflags = hw[4];
      dst_idx  = lw[11:8];
      src_idx  = hw[3:0];
      amt_idx  = lw[3:0];
    end else if ((hw & rrx_pkg::W_RSBI_MASK) == rrx_pkg::W_RSBI_HI && !lw[15]) begin
      op       = MAIN_EXT ? rrx_pkg::RRX_OP_RSB : rrx_pkg::RRX_OP_UND;
      setflags = hw[4];
      dst_idx  = lw[11:8];
      src_idx  = hw[3:0];
      rsb_imm  = modified_const_expand({hw[10], lw[14:12], lw[7:0]});
      unpred   = dst_idx == rrx_pkg::REG_SP || dst_idx == rrx_pkg::REG_PC
              || src_idx == rrx_pkg::REG_SP || src_idx == rrx_pkg::REG_PC;
    end
  end

  // rotate amount: constant or low byte of the amount register
  assign rot_amt = (op == rrx_pkg::RRX_OP_RORI) ? {3'h0, imm_amt} : i_amt_val[7:0];

  rrx_rot u_rot (
    .i_val  (i_src_val),
    .i_amt  (rot_amt),
    .i_cin  (i_flags[rrx_pkg::FLAG_C]),
    .o_res  (rot_val),
    .o_cout (rot_c)
  );

  // result and carry/overflow per operation
  always_comb begin
    sum   = {1'b0, rsb_imm} + {1'b0, ~i_src_val} + 33'h1;
    res   = rot_val;
    c_out = rot_c;
    v_out = i_flags[rrx_pkg::FLAG_V];
    case (op)
      rrx_pkg::RRX_OP_RRX: begin
        res   = {i_flags[rrx_pkg::FLAG_C], i_src_val[31:1]};
        c_out = i_src_val[0];
      end
      rrx_pkg::RRX_OP_RSB: begin
        res   = sum[31:0];
        c_out = sum[32];
        v_out = (rsb_imm[31] == ~i_src_val[31]) && (sum[31] != rsb_imm[31]);
      end
      default: begin
        res   = rot_val;
        c_out = rot_c;
      end
    endcase
  end

  logic        wr_en_d, wr_en_q, fl_wr_d, fl_wr_q, und_d, und_q, unp_d, unp_q;
  logic [3:0]  idx_d, idx_q, flags_d, flags_q;
  logic [31:0] data_d, data_q;
  logic        exec;

  // writeback next values; failed condition blocks the writes and unpred, but not undef
  always_comb begin
    exec    = i_valid && i_cond_pass && op != rrx_pkg::RRX_OP_NONE
              && op != rrx_pkg::RRX_OP_UND;
    wr_en_d = exec;
    idx_d   = dst_idx;
    data_d  = res;
    fl_wr_d = exec && setflags;
    flags_d = i_flags;
    if (fl_wr_d) begin
      flags_d[rrx_pkg::FLAG_N] = res[31];
      flags_d[rrx_pkg::FLAG_Z] = (res == 32'h0);
      flags_d[rrx_pkg::FLAG_C] = c_out;
      flags_d[rrx_pkg::FLAG_V] = v_out;
    end
    und_d = i_valid && op == rrx_pkg::RRX_OP_UND;
    unp_d = exec && unpred;
  end

  // register the writeback
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_en_q <= 1'b0;
      idx_q   <= 4'h0;
      data_q  <= rrx_pkg::RESULT_RST;
      fl_wr_q <= 1'b0;
      flags_q <= rrx_pkg::FLAGS_RST;
      und_q   <= 1'b0;
      unp_q   <= 1'b0;
    end else begin
      wr_en_q <= wr_en_d;
      idx_q   <= idx_d;
      data_q  <= data_d;
      fl_wr_q <= fl_wr_d;
      flags_q <= flags_d;
      und_q   <= und_d;
      unp_q   <= unp_d;
    end
  end

  logic [3:0] sidx_q, aidx_q;
  // operand index outputs, registered to keep outputs on flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sidx_q <= 4'h0;
      aidx_q <= 4'h0;
    end else begin
      sidx_q <= src_idx;
      aidx_q <= amt_idx;
    end
  end

  assign o_wr_en    = wr_en_q;
  assign o_wr_idx   = idx_q;
  assign o_wr_data  = data_q;
  assign o_flags_wr = fl_wr_q;
  assign o_flags    = flags_q;
  assign o_undef    = und_q;
  assign o_unpred   = unp_q;
  assign o_src_idx  = sidx_q;
  assign o_amt_idx  = aidx_q;

  property p_nocond;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_valid && !i_cond_pass) |=> (!o_wr_en && !o_flags_wr);
  endproperty
  a_nocond: assert property (p_nocond) else $error("write on failed condition");

  property p_flags_n;
    @(posedge i_clk) disable iff (!i_arst_n)
      o_flags_wr |-> (o_flags[3] == o_wr_data[31] && o_flags[2] == (o_wr_data == 32'h0));
  endproperty
  a_flags_n: assert property (p_flags_n) else $error("n or z mismatch");

  property p_rrx;
    @(posedge i_clk) disable iff (!i_arst_n)
      (op == rrx_pkg::RRX_OP_RRX && exec)
        |=> o_wr_data == {$past(i_flags[1]), $past(i_src_val[31:1])};
  endproperty
  a_rrx: assert property (p_rrx) else $error("extended rotate wrong");

  property p_rsb;
    @(posedge i_clk) disable iff (!i_arst_n)
      (op == rrx_pkg::RRX_OP_RSB && exec) |=> o_wr_data == $past(rsb_imm - i_src_val);
  endproperty
  a_rsb: assert property (p_rsb) else $error("reverse subtract wrong");

  property p_undef;
    @(posedge i_clk) disable iff (!i_arst_n)
      o_undef |-> !o_wr_en && !o_flags_wr;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined op wrote");

  property p_short_ror;
    @(posedge i_clk) disable iff (!i_arst_n)
      (exec && !i_is_wide && op == rrx_pkg::RRX_OP_RORR) |=> o_flags_wr == !$past(i_in_block);
  endproperty
  a_short_ror: assert property (p_short_ror) else $error("short rotate flags");

  property p_zero_amt;
    @(posedge i_clk) disable iff (!i_arst_n)
      (exec && op == rrx_pkg::RRX_OP_RORR && i_amt_val[7:0] == 8'h00)
        |=> o_wr_data == $past(i_src_val) && o_flags[1] == $past(i_flags[1]);
  endproperty
  a_zero_amt: assert property (p_zero_amt) else $error("zero rotate changed");

  // constant rotate checked against the raw amount fields, not the decoded amount
  property p_rori;
    @(posedge i_clk) disable iff (!i_arst_n)
      (exec && op == rrx_pkg::RRX_OP_RORI)
        |=> o_wr_data == 32'({$past(i_src_val), $past(i_src_val)} >> $past({lw[14:12], lw[7:6]}));
  endproperty
  a_rori: assert property (p_rori) else $error("constant rotate wrong");

  // all-zero amount fields must fall through to the extended rotate
  property p_const_zero;
    @(posedge i_clk) disable iff (!i_arst_n)
      (MAIN_EXT && i_valid && i_cond_pass && i_is_wide
       && (hw & rrx_pkg::W_MOV_MASK) == rrx_pkg::W_MOV_HI && lw[5:4] == rrx_pkg::SHIFT_ROR
       && lw[14:12] == 3'h0 && lw[7:6] == 2'h0)
        |=> o_wr_data == {$past(i_flags[1]), $past(i_src_val[31:1])};
  endproperty
  a_const_zero: assert property (p_const_zero) else $error("zero amount rotated");

  property p_rrx_carry;
    @(posedge i_clk) disable iff (!i_arst_n)
      (exec && op == rrx_pkg::RRX_OP_RRX && setflags) |=> o_flags[1] == $past(i_src_val[0]);
  endproperty
  a_rrx_carry: assert property (p_rrx_carry) else $error("extended rotate carry");

  // register rotate only sees the low bits of the amount register
  property p_reg_rot;
    @(posedge i_clk) disable iff (!i_arst_n)
      (exec && op == rrx_pkg::RRX_OP_RORR)
        |=> o_wr_data == 32'({$past(i_src_val), $past(i_src_val)} >> $past(i_amt_val[4:0]));
  endproperty
  a_reg_rot: assert property (p_reg_rot) else $error("register rotate wrong");

  property p_short_neg;
    @(posedge i_clk) disable iff (!i_arst_n)
      (exec && !i_is_wide && op == rrx_pkg::RRX_OP_RSB)
        |=> o_wr_data == 32'h0 - $past(i_src_val) && o_flags_wr == !$past(i_in_block);
  endproperty
  a_short_neg: assert property (p_short_neg) else $error("short negate wrong");

  // sp or pc in the wide form still executes, but is reported
  property p_unpred;
    @(posedge i_clk) disable iff (!i_arst_n)
      (exec && i_is_wide && op == rrx_pkg::RRX_OP_RSB
       && (lw[11:8] == rrx_pkg::REG_SP || hw[3:0] == rrx_pkg::REG_PC))
        |=> o_unpred && o_wr_en;
  endproperty
  a_unpred: assert property (p_unpred) else $error("unpredictable regs missed");
endmodule : rrx_exec

//--- bench/rrx_tb_pkg.sv
// shared request record for the fetch model and the bench
// assumes the design's flag word order n,z,c,v
package rrx_tb_pkg;
  // one issued instruction plus the result it must produce
  typedef struct packed {
    logic [31:0] instr;
    logic        wide;
    logic        blk;
    logic        cond;
    logic [31:0] src;
    logic [31:0] amt;
    logic [3:0]  fl;
    logic        e_wr;
    logic [3:0]  e_idx;
    logic [31:0] e_data;
    logic        e_fwr;
    logic [3:0]  e_fl;
    logic        e_unp;
    logic [3:0]  e_sidx;
    logic [3:0]  e_aidx;
  } rrx_req_t;
endpackage : rrx_tb_pkg

//--- bench/rrx_fetch_model.sv
// fetch stage model: presents queued instructions with their operands
// assumes requests are pushed away from the rising edge
module rrx_fetch_model (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  output logic             o_valid,
  output logic      [31:0] o_instr,
  output logic             o_is_wide,
  output logic             o_in_block,
  output logic             o_cond_pass,
  output logic      [31:0] o_src_val,
  output logic      [31:0] o_amt_val,
  output logic      [3:0]  o_flags
);
  timeunit 1ns;
  timeprecision 100ps;
  rrx_tb_pkg::rrx_req_t q[$];
  rrx_tb_pkg::rrx_req_t cur;
  rrx_tb_pkg::rrx_req_t nx;

  task automatic push(input rrx_tb_pkg::rrx_req_t r);
    q.push_back(r);
  endtask : push

  // defined levels before the first reset edge
  initial {o_valid, o_instr, o_is_wide, o_in_block, o_cond_pass, o_src_val, o_amt_val, o_flags} = '0;

  // one request a cycle; when idle the instruction, source and amount values toggle so stale operands never look valid
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {o_valid, o_instr, o_is_wide, o_in_block, o_cond_pass} <= '0;
      {o_src_val, o_amt_val, o_flags} <= '0;
    end else if (q.size() > 0) begin
      nx = q.pop_front();
      cur <= nx;
      {o_valid, o_instr, o_is_wide, o_in_block, o_cond_pass} <= {1'b1, nx.instr, nx.wide, nx.blk, nx.cond};
      {o_src_val, o_amt_val, o_flags} <= {nx.src, nx.amt, nx.fl};
    end else begin
      o_valid <= 1'b0;
      o_instr <= ~o_instr;
      o_src_val <= ~o_src_val;
      o_amt_val <= ~o_amt_val;
    end
  end
endmodule : rrx_fetch_model

//--- bench/tb_rotate_and_reverse_subtract_exec.sv
// self-checking bench for the rotate / reverse-subtract execute block
// assumes results appear at the taking edge and are steady by the next falling edge
module tb_rotate_and_reverse_subtract_exec;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk    = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        f_valid, f_wide, f_blk, f_cond;
  logic [31:0] f_instr, f_src, f_amt;
  logic [3:0]  f_fl, wr_idx, flags;
  logic        wr_en, flags_wr, undef, unpred, undef2;
  logic [31:0] wr_data;
  logic [3:0]  src_idx, amt_idx;
  int          error_cnt   = 0;
  int          checks_done = 0;
  rrx_tb_pkg::rrx_req_t ex = '0;

  rrx_fetch_model fm (.i_clk(i_clk), .i_arst_n(i_arst_n), .o_valid(f_valid), .o_instr(f_instr),
    .o_is_wide(f_wide), .o_in_block(f_blk), .o_cond_pass(f_cond), .o_src_val(f_src),
    .o_amt_val(f_amt), .o_flags(f_fl));
  rrx_exec #(.MAIN_EXT(1'b1)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_valid(f_valid),
    .i_instr(f_instr), .i_is_wide(f_wide), .i_in_block(f_blk), .i_cond_pass(f_cond),
    .i_src_val(f_src), .i_amt_val(f_amt), .i_flags(f_fl), .o_wr_en(wr_en), .o_wr_idx(wr_idx),
    .o_wr_data(wr_data), .o_flags_wr(flags_wr), .o_flags(flags), .o_undef(undef),
    .o_unpred(unpred), .o_src_idx(src_idx), .o_amt_idx(amt_idx));
  // same stream into a core without the main extension
  rrx_exec #(.MAIN_EXT(1'b0)) dut_base (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_valid(f_valid),
    .i_instr(f_instr), .i_is_wide(f_wide), .i_in_block(f_blk), .i_cond_pass(f_cond),
    .i_src_val(f_src), .i_amt_val(f_amt), .i_flags(f_fl), .o_wr_en(), .o_wr_idx(),
    .o_wr_data(), .o_flags_wr(), .o_flags(), .o_undef(undef2), .o_unpred(),
    .o_src_idx(), .o_amt_idx());

  always #25 i_clk = ~i_clk;

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // k: 0 rotate, 1 extended rotate, 2 reverse subtract; m: wide,block,cond,setf,unpred
  task automatic send(input int k, input logic [31:0] ins, input logic [4:0] m,
                      input logic [31:0] s, input logic [31:0] a, input logic [3:0] fl,
                      input logic [3:0] idx, input logic [7:0] si);
    rrx_tb_pkg::rrx_req_t r;
    logic [31:0] d;
    logic        cy;
    logic        ov;
    r = '{ins, m[4], m[3], m[2], s, a, fl, m[2], idx, 32'h0, m[2] & m[1], 4'h0, m[0],
          si[7:4], si[3:0]};
    ov = fl[rrx_pkg::FLAG_V];
    case (k)
      0: begin
        d = (a[7:0] == 8'h0) ? s : ((s >> a[4:0]) | (s << (6'd32 - {1'b0, a[4:0]})));
        cy = (a[7:0] == 8'h0) ? fl[rrx_pkg::FLAG_C] : d[31];
      end
      1: begin
        d = {fl[rrx_pkg::FLAG_C], s[31:1]};
        cy = s[0];
      end
      default: begin
        {cy, d} = {1'b0, a} + {1'b0, ~s} + 33'h1;
        ov = (a[31] == ~s[31]) && (d[31] != a[31]);
      end
    endcase
    r.e_data = d;
    r.e_fl = {d[31], d == 32'h0, cy, ov};
    fm.push(r);
  endtask : send

  task automatic flush(input string nm);
    int n;
    n = fm.q.size() + 3;
    repeat (n) @(negedge i_clk);
    $display("test %s done", nm);
  endtask : flush

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // expectation of the request the design takes at this edge
  always @(posedge i_clk) ex <= f_valid ? fm.cur : '0;

  // results stand for one cycle only, so every cycle is compared
  always @(negedge i_clk) begin
    if (i_arst_n) begin
      chk_bit(wr_en, ex.e_wr);
      chk_bit(flags_wr, ex.e_fwr);
      chk_bit(unpred, ex.e_unp);
      chk_bit(undef, 1'b0);
      chk_bit(undef2, ex.wide);
      if (ex.e_wr) chk_val({28'h0, wr_idx}, {28'h0, ex.e_idx});
      if (ex.e_wr) chk_val(wr_data, ex.e_data);
      if (ex.e_fwr) chk_val({28'h0, flags}, {28'h0, ex.e_fl});
      if (ex.e_wr) chk_val({28'h0, src_idx}, {28'h0, ex.e_sidx});
      if (ex.e_aidx != 4'h0) chk_val({28'h0, amt_idx}, {28'h0, ex.e_aidx});
    end
  end

  // hang guard: the sequence needs well under a hundred cycles
  initial begin
    repeat (2000) @(posedge i_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(negedge i_clk);
    send(0, 32'hea5f0273, 5'b10110, 32'h80000001, 32'd1, 4'h0, 4'h2, 8'h30);
    send(0, 32'hea5f74f5, 5'b10110, 32'h00000001, 32'd31, 4'h2, 4'h4, 8'h50);
    flush("constant rotate");
    send(1, 32'hea5f0637, 5'b10110, 32'h3, 32'h0, 4'h2, 4'h6, 8'h70);
    send(1, 32'hea5f0637, 5'b10110, 32'h2, 32'h0, 4'h9, 4'h6, 8'h70);
    send(1, 32'hea4f0637, 5'b10100, 32'h3, 32'h0, 4'h2, 4'h6, 8'h70);
    flush("extended rotate");
    send(0, 32'hfa71f809, 5'b10110, 32'h0000000f, 32'hffffff04, 4'h0, 4'h8, 8'h19);
    send(0, 32'hfa71f809, 5'b10110, 32'h80000000, 32'h00000100, 4'h0, 4'h8, 8'h19);
    send(0, 32'h000041d5, 5'b00110, 32'h12345678, 32'h8, 4'h0, 4'h5, 8'h52);
    send(0, 32'h000041d5, 5'b01100, 32'h12345678, 32'h8, 4'h0, 4'h5, 8'h52);
    flush("register rotate");
    send(2, 32'hf1d10105, 5'b10110, 32'h7, 32'h5, 4'h0, 4'h1, 8'h10);
    send(2, 32'hf1d112ab, 5'b10110, 32'h00ab00ab, 32'h00ab00ab, 4'h0, 4'h2, 8'h10);
    send(2, 32'hf5d10300, 5'b10110, 32'h80000000, 32'h00800000, 4'h0, 4'h3, 8'h10);
    send(2, 32'hf1c10105, 5'b10100, 32'h7, 32'h5, 4'h0, 4'h1, 8'h10);
    send(2, 32'hf1d10d05, 5'b10111, 32'h7, 32'h5, 4'h0, 4'hd, 8'h10);
    flush("wide reverse subtract");
    send(2, 32'h0000425c, 5'b00110, 32'h0, 32'h0, 4'h0, 4'h4, 8'h30);
    send(2, 32'h0000425c, 5'b01100, 32'h1, 32'h0, 4'h0, 4'h4, 8'h30);
    send(2, 32'h0000425c, 5'b00010, 32'h1, 32'h0, 4'h0, 4'h4, 8'h30);
    flush("short negate");
    complete_run();
  end
endmodule : tb_rotate_and_reverse_subtract_exec
